// [rtl/mc_code_encoder.sv]
// Builds the 16-bit architectural error code from an error kind and sub-fields.
// Assumes inputs are on the same clock; the output is purely combinational.
`timescale 1ns/1ps
`include "mc_logger_params.svh"
module mc_code_encoder
  import mc_logger_pkg::*;
(
  input wire error_kind_t kind_in,
  input wire logic filter_in,
  input wire logic [1:0] transaction_type_field_in,
  input wire logic [1:0] hierarchy_level_field_in,
  input wire logic [3:0] request_kind_field_in,
  input wire logic [2:0] memory_transaction_field_in,
  input wire logic [3:0] memory_channel_field_in,
  input wire logic [1:0] participation_field_in,
  input wire logic timeout_in,
  input wire logic [1:0] memory_or_io_field_in,
  input wire logic [9:0] detail_in,
  output logic [15:0] code_out
);
  logic [1:0] tt;
  logic [15:0] f;

  always_comb begin
    tt = (transaction_type_field_in == `TT_RESERVED) ? `TT_GENERIC
        : transaction_type_field_in;
    f = {3'h0, filter_in, 12'h000};
    case (kind_in)
      kind_none: code_out = `CODE_NONE;
      kind_unclassified: code_out = `CODE_UNCLASSIFIED;
      kind_urom_parity: code_out = `CODE_UROM_PARITY;
      kind_external: code_out = `CODE_EXTERNAL;
      kind_redundancy: code_out = `CODE_REDUNDANCY;
      kind_int_parity: code_out = `CODE_INT_PARITY;
      kind_int_timer: code_out = `CODE_INT_TIMER;
      kind_int_unclass: code_out = `CODE_INT_UNCLASS
          | {6'h00, (detail_in == 10'h000) ? 10'h001 : detail_in};
      kind_gen_cache: code_out = f | `CODE_GEN_CACHE
          | {14'h0000, hierarchy_level_field_in};
      kind_tlb: code_out = f | `CODE_TLB
          | {12'h000, tt, hierarchy_level_field_in};
      kind_memctl: code_out = f | `CODE_MEMCTL
          | {9'h000, memory_transaction_field_in, memory_channel_field_in};
      kind_cache: code_out = f | `CODE_CACHE
          | {8'h00, request_kind_field_in, tt, hierarchy_level_field_in};
      kind_bus: code_out = f | `CODE_BUS
          | {4'h0, participation_field_in, timeout_in, request_kind_field_in,
             memory_or_io_field_in, hierarchy_level_field_in};
      default: code_out = `CODE_UNCLASSIFIED;
    endcase
  end
endmodule

// [rtl/mc_error_logger.sv]
// Machine-check error logger: error banks, capability, exception enable, AXI4-Lite slave.
// Assumes error reports arrive on mclk_in; the external bus-init signal is asynchronous.
`timescale 1ns/1ps
`include "mc_logger_params.svh"
module mc_error_logger
  import mc_logger_pkg::*;
#(
  parameter int BANKS = `BANK_COUNT,
  parameter int FILTER_LIMIT = `FILTER_LIMIT
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic err_valid_in,
  input wire logic [1:0] err_bank_in,
  input wire error_kind_t err_kind_in,
  input wire logic err_corrected_in,
  input wire logic [1:0] transaction_type_field_in,
  input wire logic [1:0] hierarchy_level_field_in,
  input wire logic [3:0] request_kind_field_in,
  input wire logic [2:0] memory_transaction_field_in,
  input wire logic [3:0] memory_channel_field_in,
  input wire logic [1:0] participation_field_in,
  input wire logic err_timeout_in,
  input wire logic [1:0] memory_or_io_field_in,
  input wire logic [9:0] err_detail_in,
  input wire logic [15:0] err_model_code_in,
  input wire logic bus_initialization_signal_n_in,
  input wire logic bus_init_observe_strap_in,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic mc_exception_out,
  output logic [7:0] mc_vector_out
);
  typedef struct packed {
    logic [BANKS-1:0][31:0] bank_ctl;
    logic [BANKS-1:0][31:0] bank_status;
    logic [BANKS-1:0][1:0] filter_count;
    logic [31:0] global_ctl;
    logic machine_check_exception_enable;
    logic observe_strap;
    logic strap_taken;
    logic [1:0] strap_sync;
    logic [1:0] strap_age;
    logic [1:0] bus_initialization_signal_sync;
    logic bus_initialization_signal_prev;
    logic exc;
    wr_state_t wr_state;
    logic aw_held;
    logic w_held;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t st;
  state_t next_st;
  logic [15:0] arch_code;
  logic filter_flag;

  // Last corrected post before suppression carries the filter flag
  assign filter_flag = err_corrected_in
      && st.filter_count[err_bank_in] == 2'(FILTER_LIMIT - 1);

  mc_code_encoder u_encoder (
    .kind_in(err_kind_in),
    .filter_in(filter_flag),
    .transaction_type_field_in(transaction_type_field_in),
    .hierarchy_level_field_in(hierarchy_level_field_in),
    .request_kind_field_in(request_kind_field_in),
    .memory_transaction_field_in(memory_transaction_field_in),
    .memory_channel_field_in(memory_channel_field_in),
    .participation_field_in(participation_field_in),
    .timeout_in(err_timeout_in),
    .memory_or_io_field_in(memory_or_io_field_in),
    .detail_in(err_detail_in),
    .code_out(arch_code)
  );

  // Bank index of a word-aligned address inside the bank window, BANKS otherwise
  function automatic int bank_of(input logic [11:0] a);
    if (a[11:8] == 4'(`BANK_BASE >> 8) && int'(a[7:4]) < BANKS && a[1:0] == 2'h0) begin
      return int'(a[7:4]);
    end
    return BANKS;
  endfunction

  // Register slot inside a bank window
  function automatic logic is_ctl_slot(input logic [11:0] a);
    return a[3:0] == `BANK_CTL_SLOT;
  endfunction

  function automatic logic is_status_slot(input logic [11:0] a);
    return a[3:0] == `BANK_STATUS_SLOT;
  endfunction

  // Status word: valid flag, model code, architectural code
  function automatic logic [31:0] status_word(input logic [15:0] code,
      input logic [14:0] model);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`STATUS_VALID_BIT] = 1'b1;
    w[`STATUS_VALID_BIT-1:`STATUS_MODEL_LSB] = model;
    w[`STATUS_MODEL_LSB-1:0] = code;
    return w;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] cap_value();
    logic [31:0] c;
    c = 32'h0000_0000;
    c[7:0] = 8'(BANKS);
    c[`CAP_CTL_P_BIT] = 1'b1;
    c[`CAP_FILTER_BIT] = 1'b1;
    return c;
  endfunction

  always_comb begin
    int wb;
    int rb;
    logic do_write;
    logic post;
    logic bus_initialization_signal_edge;
    logic aw_take;
    logic w_take;
    logic ar_take;
    wb = BANKS;
    rb = BANKS;
    do_write = 1'b0;
    post = 1'b0;
    bus_initialization_signal_edge = 1'b0;
    aw_take = s_axi_awvalid && s_axi_awready;
    w_take = s_axi_wvalid && s_axi_wready;
    ar_take = s_axi_arvalid && s_axi_arready;
    next_st = st;

    // Strap passes two flops, then is caught once
    next_st.strap_sync = {st.strap_sync[0], bus_init_observe_strap_in};
    if (!st.strap_taken) begin
      next_st.strap_age = st.strap_age + 2'h1;
      if (st.strap_age == `STRAP_SETTLE) begin
        next_st.observe_strap = st.strap_sync[1];
        next_st.strap_taken = 1'b1;
      end
    end
    next_st.bus_initialization_signal_sync = {st.bus_initialization_signal_sync[0], ~bus_initialization_signal_n_in};
    next_st.bus_initialization_signal_prev = st.bus_initialization_signal_sync[1];
    bus_initialization_signal_edge = st.bus_initialization_signal_sync[1] && !st.bus_initialization_signal_prev;

    // Write channel
    if (aw_take) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (w_take) begin
      next_st.w_held = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.wr_state == wr_idle && st.aw_held && st.w_held) begin
      do_write = 1'b1;
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.wr_state = wr_resp;
      next_st.bresp = `RESP_OKAY;
      wb = bank_of(st.awaddr);
      if (wb < BANKS) begin
        if (is_ctl_slot(st.awaddr)) begin
          next_st.bank_ctl[wb] = merge(st.bank_ctl[wb], st.wdata, st.wstrb);
        end else if (is_status_slot(st.awaddr)) begin
          next_st.bank_status[wb] = merge(st.bank_status[wb], st.wdata, st.wstrb);
          if (st.wdata == 32'h0000_0000) begin
            next_st.filter_count[wb] = 2'h0;
          end
        end else begin
          next_st.bresp = `RESP_SLVERR;
        end
      end else if (st.awaddr == `GCTL_OFFSET) begin
        next_st.global_ctl = merge(st.global_ctl, st.wdata, st.wstrb);
      end else if (st.awaddr == `CR4_OFFSET) begin
        if (st.wstrb[0]) begin
          next_st.machine_check_exception_enable = st.wdata[`CR4_MCE_BIT];
        end
      end else if (st.awaddr != `CAP_OFFSET && st.awaddr != `STRAP_OFFSET) begin
        next_st.bresp = `RESP_SLVERR;
      end
    end
    if (st.wr_state == wr_resp && s_axi_bready) begin
      next_st.wr_state = wr_idle;
    end

    // Error posting wins over a software write to the same bank
    if (err_valid_in && int'(err_bank_in) < BANKS) begin
      post = 1'b1;
      if (err_corrected_in && st.filter_count[err_bank_in] == 2'(FILTER_LIMIT)) begin
        post = 1'b0;
      end
      if (st.bank_ctl[err_bank_in] == 32'h0000_0000) begin
        post = 1'b0;
      end
      if (post) begin
        next_st.bank_status[err_bank_in] = status_word(arch_code,
            err_model_code_in[14:0]);
        if (err_corrected_in) begin
          next_st.filter_count[err_bank_in] = st.filter_count[err_bank_in] + 2'h1;
        end
        if (!err_corrected_in && st.machine_check_exception_enable) begin
          next_st.exc = 1'b1;
        end
      end
    end
    if (bus_initialization_signal_edge && st.observe_strap && st.machine_check_exception_enable
        && st.bank_ctl[0] != 32'h0000_0000) begin
      next_st.bank_status[0] = status_word(`CODE_EXTERNAL, 15'h0000);
      next_st.exc = 1'b1;
    end
    if (!st.machine_check_exception_enable) begin
      next_st.exc = 1'b0;
    end else if (do_write && st.awaddr == `CR4_OFFSET && st.wstrb[0]
        && !st.wdata[`CR4_MCE_BIT]) begin
      next_st.exc = 1'b0;
    end

    // Read channel
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      rb = bank_of(s_axi_araddr);
      if (rb < BANKS) begin
        if (is_ctl_slot(s_axi_araddr)) begin
          next_st.rdata = st.bank_ctl[rb];
        end else if (is_status_slot(s_axi_araddr)) begin
          next_st.rdata = st.bank_status[rb];
        end else begin
          next_st.rresp = `RESP_SLVERR;
        end
      end else if (s_axi_araddr == `CAP_OFFSET) begin
        next_st.rdata = cap_value();
      end else if (s_axi_araddr == `GCTL_OFFSET) begin
        next_st.rdata = st.global_ctl;
      end else if (s_axi_araddr == `CR4_OFFSET) begin
        next_st.rdata[`CR4_MCE_BIT] = st.machine_check_exception_enable;
      end else if (s_axi_araddr == `STRAP_OFFSET) begin
        next_st.rdata[0] = st.observe_strap;
        next_st.rdata[1] = st.exc;
      end else begin
        next_st.rresp = `RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
      mc_exception_out <= 1'b0;
      mc_vector_out <= 8'h00;
    end else begin
      s_axi_awready <= next_st.wr_state == wr_idle && !next_st.aw_held;
      s_axi_wready <= next_st.wr_state == wr_idle && !next_st.w_held;
      s_axi_arready <= !next_st.rvalid;
      s_axi_bvalid <= next_st.wr_state == wr_resp;
      s_axi_bresp <= next_st.bresp;
      s_axi_rvalid <= next_st.rvalid;
      s_axi_rdata <= next_st.rdata;
      s_axi_rresp <= next_st.rresp;
      mc_exception_out <= next_st.exc;
      mc_vector_out <= `MC_VECTOR;
    end
  end
endmodule

// [rtl/mc_logger_params.svh]
// Constants for the error-code logger: register offsets, code fields, sizes.
// Included by the package and by the design modules; definitions only.
`ifndef MC_LOGGER_PARAMS_SVH
`define MC_LOGGER_PARAMS_SVH

`define BANK_COUNT 4
`define FILTER_LIMIT 3
`define MC_VECTOR 8'h12
`define STRAP_SETTLE 2'h2

`define CAP_OFFSET 12'h000
`define GCTL_OFFSET 12'h004
`define CR4_OFFSET 12'h008
`define STRAP_OFFSET 12'h00c
`define BANK_BASE 12'h100
`define BANK_CTL_SLOT 4'h0
`define BANK_STATUS_SLOT 4'h4

`define CAP_FILTER_BIT 11
`define CAP_CTL_P_BIT 8
`define CR4_MCE_BIT 6
`define STATUS_VALID_BIT 31
`define STATUS_MODEL_LSB 16
`define FILTER_BIT 12

`define CODE_NONE 16'h0000
`define CODE_UNCLASSIFIED 16'h0001
`define CODE_UROM_PARITY 16'h0002
`define CODE_EXTERNAL 16'h0003
`define CODE_REDUNDANCY 16'h0004
`define CODE_INT_PARITY 16'h0005
`define CODE_INT_TIMER 16'h0400
`define CODE_INT_UNCLASS 16'h0400
`define CODE_GEN_CACHE 16'h000c
`define CODE_TLB 16'h0010
`define CODE_MEMCTL 16'h0080
`define CODE_CACHE 16'h0100
`define CODE_BUS 16'h0800

`define TT_GENERIC 2'h2
`define TT_RESERVED 2'h3

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [rtl/mc_logger_pkg.sv]
// Types shared by the error-code logger modules.
// Assumes mc_logger_params.svh for all numeric constants.
`include "mc_logger_params.svh"
package mc_logger_pkg;

  typedef enum logic [3:0] {
    kind_none = 4'h0,
    kind_unclassified = 4'h1,
    kind_urom_parity = 4'h2,
    kind_external = 4'h3,
    kind_redundancy = 4'h4,
    kind_int_parity = 4'h5,
    kind_int_timer = 4'h6,
    kind_int_unclass = 4'h7,
    kind_gen_cache = 4'h8,
    kind_tlb = 4'h9,
    kind_memctl = 4'ha,
    kind_cache = 4'hb,
    kind_bus = 4'hc
  } error_kind_t;

  typedef enum logic [1:0] {
    wr_idle = 2'h0,
    wr_resp = 2'h1
  } wr_state_t;

endpackage

// [sim/mc_logger_sva.sv]
// Concurrent checks on the error-code logger top-level ports.
// Assumes one clock domain and the port names of mc_error_logger.
`timescale 1ns/1ps
`include "mc_logger_params.svh"
module mc_logger_sva #(
  parameter int BANKS = 4,
  parameter int FILTER_LIMIT = 3
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic err_valid_in,
  input wire logic bus_initialization_signal_n_in,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mc_exception_out,
  input wire logic [7:0] mc_vector_out
);
  logic [7:0] since_cause;
  // Cycles since the last error report or bus-init assertion
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      since_cause <= 8'hff;
    end else if (err_valid_in || !bus_initialization_signal_n_in) begin
      since_cause <= 8'h00;
    end else if (since_cause != 8'hff) begin
      since_cause <= since_cause + 8'h01;
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  vector_value_a:
    assert property ($past(rst_n_in) |-> mc_vector_out == 8'h12) else $error("bad vector");
  exc_cause_a:
    assert property ($rose(mc_exception_out) |-> since_cause <= 8'h06)
      else $error("exception without cause");
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
  write_answer_a:
    assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |-> ##[1:8] s_axi_bvalid)
      else $error("no write response");
  read_answer_a:
    assert property (s_axi_arvalid && !s_axi_rvalid |-> ##[1:8] s_axi_rvalid)
      else $error("no read response");
  valid_code_a:
    assert property (s_axi_rvalid && s_axi_rdata[31] |-> s_axi_rdata[15:0] != 16'h0000)
      else $error("valid entry with empty code");
  tlb_type_a:
    assert property (s_axi_rvalid && s_axi_rdata[31] && s_axi_rdata[15:13] == 3'h0
      && s_axi_rdata[11:4] == 8'h01 |-> s_axi_rdata[3:2] != 2'h3) else $error("tlb type 11");
  cache_type_a:
    assert property (s_axi_rvalid && s_axi_rdata[31] && s_axi_rdata[15:13] == 3'h0
      && s_axi_rdata[11:8] == 4'h1 |-> s_axi_rdata[3:2] != 2'h3) else $error("cache type 11");
  cover property ($rose(mc_exception_out));
  cover property (s_axi_rvalid && s_axi_rdata[31] && s_axi_rdata[12]);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind mc_error_logger mc_logger_sva #(.BANKS(BANKS), .FILTER_LIMIT(FILTER_LIMIT)) u_mc_logger_sva (
  .mclk_in, .rst_n_in, .err_valid_in, .bus_initialization_signal_n_in, .s_axi_awvalid,
  .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .mc_exception_out, .mc_vector_out);

// [sim/testbench.sv]
// Self-checking bench for the error-code logger with an AXI4-Lite master.
// Assumes the logger's default bank count and a filter limit of three.
`timescale 1ns/1ps
module testbench
  import mc_logger_pkg::*;
;
  localparam int FILT = 3;
  logic mclk_in, rst_n_in, err_valid_in, err_corrected_in, err_timeout_in;
  logic bus_initialization_signal_n_in, bus_init_observe_strap_in, mc_exception_out;
  error_kind_t err_kind_in;
  logic [1:0] err_bank_in, transaction_type_field_in, hierarchy_level_field_in, resp, b;
  logic [1:0] participation_field_in, memory_or_io_field_in, s_axi_bresp, s_axi_rresp;
  logic [3:0] request_kind_field_in, memory_channel_field_in, s_axi_wstrb;
  logic [2:0] memory_transaction_field_in;
  logic [9:0] err_detail_in;
  logic [15:0] err_model_code_in;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, lfsr, exp_st, keep, got;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] mc_vector_out;
  int err_count, n_tests;
  mc_error_logger #(.FILTER_LIMIT(FILT)) u_mc_error_logger (.*);

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Reference encoding of the architectural code from the driven sub-fields
  function automatic logic [15:0] exp_code(input error_kind_t k, input logic f);
    logic [1:0] tt;
    logic [1:0] ll;
    logic [15:0] c;
    tt = (transaction_type_field_in == 2'h3) ? 2'h2 : transaction_type_field_in;
    ll = hierarchy_level_field_in;
    case (k)
      kind_unclassified: c = 16'h0001;
      kind_urom_parity: c = 16'h0002;
      kind_external: c = 16'h0003;
      kind_redundancy: c = 16'h0004;
      kind_int_parity: c = 16'h0005;
      kind_int_timer: c = 16'h0400;
      kind_int_unclass: c = {6'h01, err_detail_in};
      kind_gen_cache: c = {14'h0003, ll};
      kind_tlb: c = {12'h001, tt, ll};
      kind_memctl: c = {9'h001, memory_transaction_field_in, memory_channel_field_in};
      kind_cache: c = {8'h01, request_kind_field_in, tt, ll};
      kind_bus: c = {5'h01, participation_field_in, err_timeout_in, request_kind_field_in,
        memory_or_io_field_in, ll};
      default: c = 16'h0000;
    endcase
    c[12] = f;
    return c;
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done, b_done;
    {aw_done, w_done, b_done} = 3'h0;
    @(posedge mclk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(aw_done && w_done && b_done)) begin
      @(posedge mclk_in);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (!b_done && s_axi_bvalid) begin
        b_done = 1'b1;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_done, r_done;
    {ar_done, r_done} = 2'h0;
    @(posedge mclk_in);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!(ar_done && r_done)) begin
      @(posedge mclk_in);
      if (!ar_done && s_axi_arready) begin
        ar_done = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
      if (!r_done && s_axi_rvalid) begin
        r_done = 1'b1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask

  task automatic post(input error_kind_t k, input logic [1:0] bk, input logic corr,
    input logic f);
    lfsr = lfsr_next(lfsr);
    @(posedge mclk_in);
    err_valid_in <= 1'b1;
    err_kind_in <= k;
    err_bank_in <= bk;
    err_corrected_in <= corr;
    transaction_type_field_in <= lfsr[1:0];
    hierarchy_level_field_in <= lfsr[3:2];
    request_kind_field_in <= lfsr[7:4] % 4'd9;
    memory_transaction_field_in <= lfsr[10:8] % 3'd5;
    memory_channel_field_in <= lfsr[15:12];
    participation_field_in <= lfsr[17:16];
    err_timeout_in <= lfsr[18];
    memory_or_io_field_in <= {lfsr[20] | lfsr[19], lfsr[19]};
    err_detail_in <= lfsr[30:21] | 10'h001;
    err_model_code_in <= lfsr[31:16];
    @(posedge mclk_in);
    err_valid_in <= 1'b0;
    exp_st = {1'b1, err_model_code_in[14:0], exp_code(k, f)};
    repeat (2) @(posedge mclk_in);
  endtask

  task automatic bus_init_pulse;
    @(posedge mclk_in);
    bus_initialization_signal_n_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    bus_initialization_signal_n_in <= 1'b1;
    repeat (6) @(posedge mclk_in);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_in);
    err_count++;
    report_and_stop;
  end

  initial begin
    {rst_n_in, err_valid_in, err_corrected_in, err_timeout_in, s_axi_awvalid} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, err_bank_in} = '0;
    {transaction_type_field_in, hierarchy_level_field_in, participation_field_in} = '0;
    {memory_or_io_field_in, request_kind_field_in, memory_channel_field_in} = '0;
    {memory_transaction_field_in, err_detail_in, err_model_code_in} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {bus_initialization_signal_n_in, bus_init_observe_strap_in, s_axi_wstrb} = 6'h3f;
    err_kind_in = kind_none;
    {err_count, n_tests} = '0;
    lfsr = 32'h0936;
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    axi_write(12'h000, 32'h0, resp);
    check("capability write resp", 32'h0, {30'h0, resp});
    axi_write(12'h0f0, 32'h0, resp);
    check("unmapped write resp", 32'h2, {30'h0, resp});
    axi_read(12'h000, got, resp);
    check("capability", 32'h0000_0904, got);
    axi_read(12'h0f0, got, resp);
    check("unmapped resp", 32'h2, {30'h0, resp});
    $display("test capability done");
    bus_init_pulse;
    check("exception disabled", 32'h0, {31'h0, mc_exception_out});
    for (int i = 0; i < 4; i++) begin
      b = i[1:0];
      axi_write(12'h100 + {6'h00, b, 4'h0}, 32'hffff_ffff, resp);
      axi_read(12'h100 + {6'h00, b, 4'h0}, got, resp);
      check("bank control", 32'hffff_ffff, got);
      axi_write(12'h104 + {6'h00, b, 4'h0}, 32'h0, resp);
      axi_read(12'h104 + {6'h00, b, 4'h0}, got, resp);
      check("status cleared", 32'h0, got);
    end
    axi_write(12'h008, 32'h0000_0040, resp);
    axi_read(12'h008, got, resp);
    check("exception enable", 32'h0000_0040, got);
    check("vector", 32'h12, {24'h0, mc_vector_out});
    $display("test init done");
    bus_init_pulse;
    check("exception raised", 32'h1, {31'h0, mc_exception_out});
    axi_read(12'h104, got, resp);
    check("bus init code", 32'h8000_0003, {got[31], 15'h0, got[15:0]});
    axi_write(12'h104, 32'h0, resp);
    $display("test bus init done");
    for (int k = 1; k <= 12; k++) begin
      b = lfsr[5:4];
      post(error_kind_t'(k[3:0]), b, 1'b0, 1'b0);
      axi_read(12'h104 + {6'h00, b, 4'h0}, got, resp);
      check("posted code", exp_st, got);
      axi_write(12'h104 + {6'h00, b, 4'h0}, 32'h0, resp);
    end
    $display("test codes done");
    for (int i = 0; i <= FILT; i++) begin
      post(kind_tlb, 2'h1, 1'b1, i == FILT - 1);
      if (i < FILT) keep = exp_st;
      axi_read(12'h114, got, resp);
      check("filtered post", keep, got);
    end
    post(kind_cache, 2'h1, 1'b0, 1'b0);
    axi_read(12'h114, got, resp);
    check("uncorrected post", exp_st, got);
    $display("test filtering done");
    report_and_stop;
  end
endmodule
